/* File: see_cfg.svh */
`ifndef SEE_CFG_SVH
`define SEE_CFG_SVH

// Slave address layout
`define SEE_SLV_ID      4'ha
`define SEE_ID_MSB      7
`define SEE_ID_LSB      4
`define SEE_RW_BIT      0

// Array and page layout
`define SEE_MEM_DEPTH   128
`define SEE_PAGE_BYTES  16
`define SEE_BITS_BYTE   4'h8
`define SEE_LAST_TXBIT  4'h7
`define SEE_LAST_ADDR   7'h7f

// Reset values
`define SEE_PTR_RST     7'h00
`define SEE_OE_N_RST    1'b1

// Timing
`define SEE_REF_CLK_MHZ 250
`define SEE_T_WR_MS     5
`define SEE_WR_CYCLES   (`SEE_T_WR_MS * 1000 * `SEE_REF_CLK_MHZ)

`endif

/* File: see_pkg.sv */
`default_nettype none

package see_pkg;

    typedef enum logic [3:0] {
        S_IDLE,
        S_ADDR,
        S_AACK,
        S_WADDR,
        S_WAACK,
        S_WDATA,
        S_DACK,
        S_RDATA,
        S_RACK,
        S_WAIT
    } see_state_type;

endpackage

`default_nettype wire

/* File: see_mem.sv */
`timescale 1ns/1ns
`default_nettype none

module see_mem (
    input  wire logic       clk,
    input  wire logic       arst_n,
    input  wire logic       wr_en,
    input  wire logic [6:0] wr_addr,
    input  wire logic [7:0] wr_data,
    input  wire logic [6:0] rd_addr,
    output logic      [7:0] rd_data
);

    typedef struct packed {
        logic [127:0][7:0] arr;
        logic [7:0]        rd;
    } see_mem_type;

    see_mem_type r_q;
    see_mem_type r_d;

    // ------------------------------------------------------------------
    // Array with registered read port
    // ------------------------------------------------------------------
    always_comb begin
        r_d    = r_q;
        r_d.rd = r_q.arr[rd_addr];
        if (wr_en) begin
            r_d.arr[wr_addr] = wr_data;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            r_q <= '0;
        end else begin
            r_q <= r_d;
        end
    end

    assign rd_data = r_q.rd;

endmodule

`default_nettype wire

/* File: see_eeprom.sv */
// What this block does
// - Page write of 16 bytes, one cycle
// - Ack each byte, bump low pointer bits
// - Over sixteen bytes wrap, overwrite earlier
// - Programming starts only at write stop
// - No ack to address while busy
// - Write-protect input low blocks all writes
// - Pointer holds last location plus one
// - Pointer wraps from 127 to 0 on reads
// - Random read via dummy write, then read
// - Master ack turns read sequential
// - One more byte per master ack
// - Sequential read wraps to first location
// - Release data after nack and stop
// - Match upper four bits against 1010
// - Bus interface deaf during write cycle
`include "see_cfg.svh"
`timescale 1ns/1ns
`default_nettype none

module see_eeprom #(
    parameter int WR_CYCLES = `SEE_WR_CYCLES
) (
    input  wire logic REF_CLK,
    input  wire logic ARST_N,
    input  wire logic SCL_CLK,
    input  wire logic SDA_I,
    input  wire logic TRANSMIT_ONLY_CLOCK_IN,
    output logic      SDA_O,
    output logic      SDA_OE_N,
    output logic      WRITE_BUSY
);

    typedef struct packed {
        logic bit_v;
        logic tgl;
    } see_link_type;

    typedef struct packed {
        logic                  scl_m;
        logic                  scl_s;
        logic                  scl_p;
        logic                  sda_m;
        logic                  sda_s;
        logic                  sda_p;
        logic                  wp_m;
        logic                  wp_s;
        logic                  tgl_m;
        logic                  tgl_s;
        logic                  tgl_p;
        see_pkg::see_state_type st;
        logic [3:0]            cnt;
        logic [7:0]            sh;
        logic                  rw;
        logic                  mack;
        logic [6:0]            ptr;
        logic [15:0][7:0]      pbuf;
        logic [15:0]           pval;
        logic                  busy;
        logic [20:0]           tmr;
        logic [4:0]            cidx;
        logic                  oe_n;
        logic                  sda_o;
    } see_ref_type;

    see_link_type l_q;
    see_link_type l_d;
    see_ref_type  r_q;
    see_ref_type  r_d;
    logic         start_ev;
    logic         stop_ev;
    logic         fall_ev;
    logic         bit_ev;
    logic         mem_we;
    logic [6:0]   mem_wa;
    logic [7:0]   mem_wd;
    logic [7:0]   mem_rd;

    // ------------------------------------------------------------------
    // Link domain: sample data at each serial clock rise
    // ------------------------------------------------------------------
    always_comb begin
        l_d       = l_q;
        l_d.bit_v = SDA_I;
        l_d.tgl   = ~l_q.tgl;
    end

    always_ff @(posedge SCL_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            l_q <= '0;
        end else begin
            l_q <= l_d;
        end
    end

    // ------------------------------------------------------------------
    // Bus events in the reference domain
    // ------------------------------------------------------------------
    assign start_ev = r_q.scl_s & r_q.scl_p & r_q.sda_p & ~r_q.sda_s;
    assign stop_ev  = r_q.scl_s & r_q.scl_p & ~r_q.sda_p & r_q.sda_s;
    assign fall_ev  = r_q.scl_p & ~r_q.scl_s;
    assign bit_ev   = r_q.tgl_s ^ r_q.tgl_p;

    // ------------------------------------------------------------------
    // Protocol engine
    // ------------------------------------------------------------------
    always_comb begin
        r_d       = r_q;
        r_d.scl_m = SCL_CLK;
        r_d.scl_s = r_q.scl_m;
        r_d.scl_p = r_q.scl_s;
        r_d.sda_m = SDA_I;
        r_d.sda_s = r_q.sda_m;
        r_d.sda_p = r_q.sda_s;
        r_d.wp_m  = TRANSMIT_ONLY_CLOCK_IN;
        r_d.wp_s  = r_q.wp_m;
        r_d.tgl_m = l_q.tgl;
        r_d.tgl_s = r_q.tgl_m;
        r_d.tgl_p = r_q.tgl_s;
        mem_we    = 1'b0;
        mem_wa    = {r_q.ptr[6:4], r_q.cidx[3:0]};
        mem_wd    = r_q.pbuf[r_q.cidx[3:0]];

        if (r_q.busy) begin
            if (r_q.cidx < 5'(`SEE_PAGE_BYTES)) begin
                mem_we   = r_q.pval[r_q.cidx[3:0]];
                r_d.cidx = r_q.cidx + 5'h01;
            end
            if (r_q.tmr == 21'(WR_CYCLES - 1)) begin
                r_d.busy = 1'b0;
                r_d.pval = '0;
            end else begin
                r_d.tmr = r_q.tmr + 21'h000001;
            end
        end

        if (bit_ev) begin
            case (r_q.st)
                see_pkg::S_ADDR,
                see_pkg::S_WADDR,
                see_pkg::S_WDATA: begin
                    r_d.sh  = {r_q.sh[6:0], l_q.bit_v};
                    r_d.cnt = r_q.cnt + 4'h1;
                end
                see_pkg::S_RACK: begin
                    r_d.mack = ~l_q.bit_v;
                end
                default: begin
                end
            endcase
        end

        if (start_ev) begin
            r_d.st   = see_pkg::S_ADDR;
            r_d.cnt  = 4'h0;
            r_d.oe_n = 1'b1;
            if (!r_q.busy) begin
                r_d.pval = '0;
            end
        end else if (stop_ev) begin
            r_d.st   = see_pkg::S_IDLE;
            r_d.oe_n = 1'b1;
            if (!r_q.busy && (|r_q.pval)) begin
                r_d.busy = 1'b1;
                r_d.tmr  = '0;
                r_d.cidx = '0;
            end
        end else if (fall_ev) begin
            case (r_q.st)
                see_pkg::S_ADDR: begin
                    if (r_q.cnt == `SEE_BITS_BYTE) begin
                        // match fixed id, take rw bit
                        if (r_q.sh[`SEE_ID_MSB:`SEE_ID_LSB] == `SEE_SLV_ID
                            && !r_q.busy) begin
                            r_d.st   = see_pkg::S_AACK;
                            r_d.oe_n = 1'b0;
                            r_d.rw   = r_q.sh[`SEE_RW_BIT];
                        end else begin
                            r_d.st = see_pkg::S_IDLE;
                        end
                    end
                end
                see_pkg::S_WADDR: begin
                    if (r_q.cnt == `SEE_BITS_BYTE) begin
                        r_d.ptr  = r_q.sh[6:0];
                        r_d.st   = see_pkg::S_WAACK;
                        r_d.oe_n = 1'b0;
                    end
                end
                see_pkg::S_WDATA: begin
                    if (r_q.cnt == `SEE_BITS_BYTE) begin
                        if (r_q.wp_s) begin
                            r_d.pbuf[r_q.ptr[3:0]] = r_q.sh;
                            r_d.pval[r_q.ptr[3:0]] = 1'b1;
                        end
                        r_d.ptr  = {r_q.ptr[6:4], r_q.ptr[3:0] + 4'h1};
                        r_d.st   = see_pkg::S_DACK;
                        r_d.oe_n = 1'b0;
                    end
                end
                see_pkg::S_AACK: begin
                    r_d.cnt  = 4'h0;
                    r_d.oe_n = 1'b1;
                    if (r_q.rw) begin
                        r_d.sh   = mem_rd;
                        r_d.ptr  = r_q.ptr + 7'h01;
                        r_d.oe_n = mem_rd[7];
                        r_d.st   = see_pkg::S_RDATA;
                    end else begin
                        r_d.st = see_pkg::S_WADDR;
                    end
                end
                see_pkg::S_WAACK,
                see_pkg::S_DACK: begin
                    r_d.cnt  = 4'h0;
                    r_d.oe_n = 1'b1;
                    r_d.st   = see_pkg::S_WDATA;
                end
                see_pkg::S_RDATA: begin
                    if (r_q.cnt == `SEE_LAST_TXBIT) begin
                        r_d.oe_n = 1'b1;
                        r_d.mack = 1'b0;
                        r_d.st   = see_pkg::S_RACK;
                    end else begin
                        r_d.cnt  = r_q.cnt + 4'h1;
                        r_d.sh   = {r_q.sh[6:0], 1'b0};
                        r_d.oe_n = r_q.sh[6];
                    end
                end
                see_pkg::S_RACK: begin
                    r_d.cnt = 4'h0;
                    if (r_q.mack) begin
                        r_d.sh   = mem_rd;
                        r_d.ptr  = r_q.ptr + 7'h01;
                        r_d.oe_n = mem_rd[7];
                        r_d.st   = see_pkg::S_RDATA;
                    end else begin
                        r_d.st = see_pkg::S_WAIT;
                    end
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            r_q      <= '0;
            r_q.st   <= see_pkg::S_IDLE;
            r_q.ptr  <= `SEE_PTR_RST;
            r_q.oe_n <= `SEE_OE_N_RST;
            r_q.scl_m <= 1'b1;
            r_q.scl_s <= 1'b1;
            r_q.scl_p <= 1'b1;
            r_q.sda_m <= 1'b1;
            r_q.sda_s <= 1'b1;
            r_q.sda_p <= 1'b1;
        end else begin
            r_q <= r_d;
        end
    end

    // ------------------------------------------------------------------
    // Array
    // ------------------------------------------------------------------
    see_mem u_mem (
        .clk     (REF_CLK),
        .arst_n  (ARST_N),
        .wr_en   (mem_we),
        .wr_addr (mem_wa),
        .wr_data (mem_wd),
        .rd_addr (r_q.ptr),
        .rd_data (mem_rd)
    );

    assign SDA_O      = r_q.sda_o;
    assign SDA_OE_N   = r_q.oe_n;
    assign WRITE_BUSY = r_q.busy;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!ARST_N);

    addr_match_a: assert property (
        (r_q.st == see_pkg::S_AACK && $past(r_q.st) == see_pkg::S_ADDR)
        |-> ($past(r_q.sh[7:4]) == 4'ha && r_q.oe_n == 1'b0))
        else $error("address ack without id match");

    busy_silent_a: assert property (
        $past(r_q.busy) && r_q.busy |-> r_q.st != see_pkg::S_AACK
            || $past(r_q.st) == see_pkg::S_AACK)
        else $error("address acked during write cycle");

    wr_at_stop_a: assert property (
        $rose(r_q.busy) |-> $past(stop_ev) && $past(|r_q.pval))
        else $error("write cycle began without stop");

    wp_block_a: assert property (
        !r_q.wp_s && !r_q.busy && !start_ev |=> $stable(r_q.pval))
        else $error("byte buffered while protected");

    page_inc_a: assert property (
        r_q.st == see_pkg::S_WDATA && r_d.st == see_pkg::S_DACK
        |=> r_q.ptr[6:4] == $past(r_q.ptr[6:4])
            && r_q.ptr[3:0] == $past(r_q.ptr[3:0]) + 4'h1)
        else $error("page pointer step wrong");

    ptr_wrap_a: assert property (
        r_q.ptr == 7'h7f && r_d.st == see_pkg::S_RDATA
        && r_q.st != see_pkg::S_RDATA |=> r_q.ptr == 7'h00)
        else $error("pointer did not wrap");

    load_byte_a: assert property (
        r_q.st == see_pkg::S_RACK && r_q.mack && fall_ev && !start_ev
        && !stop_ev |=> r_q.sh == $past(mem_rd)
            && r_q.oe_n == $past(mem_rd[7]))
        else $error("next read byte not loaded");

    nack_release_a: assert property (
        r_q.st == see_pkg::S_WAIT |-> r_q.oe_n == 1'b1)
        else $error("line held after master nack");

    wr_time_a: assert property (
        r_q.busy |-> r_q.tmr < 21'(WR_CYCLES))
        else $error("write cycle overran");

    page_commit_a: assert property (
        mem_we |-> r_q.busy && r_q.pval[r_q.cidx[3:0]]
            && mem_wa[6:4] == r_q.ptr[6:4])
        else $error("array write outside committed page");

endmodule

`default_nettype wire

/* File: see_master.sv */
`timescale 1ns/1ns
`default_nettype none

// ----------------------------------------
// Two-wire bus master model
// ----------------------------------------
module see_master (
    input  wire logic slow,
    input  wire logic sda,
    output var  logic scl,
    output var  logic sda_low
);
    // Clock stands high, data released
    initial begin
        scl     = 1'b1;
        sda_low = 1'b0;
    end

    // One bit slot: data set mid-low, sampled mid-high
    task automatic xfer(input logic b, output logic r);
        if (slow) #200;
        #31 sda_low = ~b;
        #31 scl = 1'b1;
        #31 r = sda;
        #32 scl = 1'b0;
    endtask

    task automatic start();
        #31 sda_low = 1'b0;
        #31 scl = 1'b1;
        #31 sda_low = 1'b1;
        #32 scl = 1'b0;
    endtask

    task automatic stop();
        #31 sda_low = 1'b1;
        #31 scl = 1'b1;
        #31 sda_low = 1'b0;
        #32;
    endtask

    task automatic wr_byte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            xfer(d[i], r);
        end
        xfer(1'b1, r);
        ack = ~r;
    endtask

    // byte in, ack for more, nack to end
    task automatic rd_byte(input logic more, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            xfer(1'b1, r);
            d[i] = r;
        end
        xfer(~more, r);
    endtask
endmodule

`default_nettype wire

/* File: see_eeprom_tb.sv */
`timescale 1ns/1ns
`default_nettype none

module see_eeprom_tb;
    localparam int WR_CYC = 2000;
    typedef struct packed {
        logic [7:0] sa;
        logic       ack;
    } see_row_type;

    logic        ref_clk, arst_n, wp, slow, scl, m_low;
    logic        sda, sda_o, sda_oe_n, busy;
    logic [7:0]  mem_e [128];
    logic [6:0]  ptr_e;
    int          fail_count, comparisons;
    see_row_type rows [7] = '{'{8'ha0, 1'b1}, '{8'hae, 1'b1},
        '{8'ha8, 1'b1}, '{8'hb0, 1'b0}, '{8'h20, 1'b0},
        '{8'he0, 1'b0}, '{8'ha6, 1'b1}};

    // Open-drain wire with pull-up
    assign sda = ~(m_low | (~sda_oe_n & ~sda_o));

    see_eeprom #(.WR_CYCLES(WR_CYC)) u_dut (
        .REF_CLK               (ref_clk),
        .ARST_N                (arst_n),
        .SCL_CLK               (scl),
        .SDA_I                 (sda),
        .TRANSMIT_ONLY_CLOCK_IN(wp),
        .SDA_O                 (sda_o),
        .SDA_OE_N              (sda_oe_n),
        .WRITE_BUSY            (busy)
    );

    see_master u_mst (
        .slow   (slow),
        .sda    (sda),
        .scl    (scl),
        .sda_low(m_low)
    );

    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end

    // ----------------------------------------
    // Checking and closing
    // ----------------------------------------
    task automatic chk(input logic ok, input string msg);
        comparisons++;
        if (ok !== 1'b1) begin
            fail_count++;
            $display("wrong value at %0t: %s", $time, msg);
        end
    endtask

    task automatic final_report();
        $display("fail_count=%0d comparisons=%0d", fail_count, comparisons);
        if (fail_count == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // ----------------------------------------
    // Bus sequences
    // ----------------------------------------
    task automatic poll(input logic busy_exp);
        logic ack;
        int   k;
        ack = 1'b0;
        k = 0;
        while (ack !== 1'b1 && k < 20) begin
            u_mst.start();
            u_mst.wr_byte(8'ha0, ack);
            u_mst.stop();
            if (k == 0 && busy_exp) chk(ack === 1'b0, "busy ack");
            k++;
        end
        chk(ack === 1'b1 && busy === 1'b0, "poll end");
    endtask

    task automatic page_wr(input logic [6:0] a, input int n,
                           input logic [7:0] base);
        logic       ack;
        logic [7:0] d;
        logic [3:0] lo;
        int         k;
        u_mst.start();
        u_mst.wr_byte(8'ha0, ack);
        chk(ack === 1'b1, "wr addr");
        u_mst.wr_byte({1'b0, a}, ack);
        chk(ack === 1'b1, "word addr");
        lo = a[3:0];
        for (int i = 0; i < n; i++) begin
            d = base + 8'(i);
            u_mst.wr_byte(d, ack);
            chk(ack === 1'b1, "data ack");
            if (wp) mem_e[{a[6:4], lo}] = d;
            lo++;
        end
        ptr_e = {a[6:4], lo};
        chk(busy === 1'b0, "early busy");
        u_mst.stop();
        if (n > 0 && wp) begin
            k = 0;
            while (busy !== 1'b1 && k < 20) begin
                @(negedge ref_clk);
                k++;
            end
            chk(busy === 1'b1, "no cycle");
        end
        poll(n > 0 && wp);
    endtask

    task automatic rd(input logic sel, input logic [6:0] a, input int n,
                      input logic [7:0] sa);
        logic       ack;
        logic [7:0] d;
        if (sel) begin
            u_mst.start();
            u_mst.wr_byte(8'ha0, ack);
            u_mst.wr_byte({1'b0, a}, ack);
            chk(ack === 1'b1, "dummy ack");
            ptr_e = a;
        end
        u_mst.start();
        u_mst.wr_byte(sa, ack);
        chk(ack === 1'b1, "rd addr");
        for (int i = 0; i < n; i++) begin
            u_mst.rd_byte(i < n - 1, d);
            chk(d === mem_e[ptr_e], "rd data");
            ptr_e++;
        end
        u_mst.stop();
        repeat (20) @(negedge ref_clk);
        chk(sda_oe_n === 1'b1 && busy === 1'b0, "release");
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        logic ack;
        arst_n = 1'b0;
        wp = 1'b1;
        slow = 1'b0;
        fail_count = 0;
        comparisons = 0;
        ptr_e = 7'h00;
        foreach (mem_e[i]) mem_e[i] = 8'h00;
        repeat (12) @(negedge ref_clk);
        chk(sda_oe_n === 1'b1 && busy === 1'b0, "reset");
        arst_n = 1'b1;
        repeat (8) @(negedge ref_clk);
        foreach (rows[i]) begin
            u_mst.start();
            u_mst.wr_byte(rows[i].sa, ack);
            chk(ack === rows[i].ack, "match");
            u_mst.stop();
        end
        rd(1'b1, 7'h00, 2, 8'ha1);
        page_wr(7'h20, 16, 8'h30);
        rd(1'b1, 7'h20, 17, 8'hab);
        page_wr(7'h45, 20, 8'h80);
        rd(1'b0, 7'h00, 2, 8'ha1);
        rd(1'b1, 7'h40, 16, 8'ha1);
        page_wr(7'h7e, 2, 8'hc0);
        rd(1'b1, 7'h7e, 4, 8'ha1);
        rd(1'b1, 7'h7f, 1, 8'ha1);
        rd(1'b0, 7'h00, 1, 8'ha1);
        @(negedge ref_clk);
        wp = 1'b0;
        slow = 1'b1;
        page_wr(7'h20, 4, 8'hf0);
        @(negedge ref_clk);
        wp = 1'b1;
        slow = 1'b0;
        rd(1'b1, 7'h20, 4, 8'ha1);
        final_report();
    end

    initial begin
        #360000;
        fail_count++;
        final_report();
    end
endmodule

`default_nettype wire
